/* pkg/fsrl_pkg.sv */
// Constants shared by the flash status register logic.
// Assumes a 100 MHz system clock and mode 0 serial framing.
package fsrl_pkg;

  // Instruction codes.
  localparam logic [7:0] OP_WRR   = 8'h01;
  localparam logic [7:0] OP_CLEAR_WRITE_ENABLE_CMD  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_ONE_CMD = 8'h05;
  localparam logic [7:0] OP_SET_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] OP_CLEAR_STATUS_CMD  = 8'h30;
  localparam logic [7:0] OP_READ_STATUS_TWO_CMD = 8'h07;
  localparam logic [7:0] OP_PROG  = 8'h02;
  localparam logic [7:0] OP_SECT  = 8'hd8;
  localparam logic [7:0] OP_BULK  = 8'h60;
  localparam logic [7:0] OP_PROGRAM_SUSPEND_CMD  = 8'h85;
  localparam logic [7:0] OP_ERASE_SUSPEND_CMD  = 8'h75;
  localparam logic [7:0] OP_SRST  = 8'hf0;

  // Field positions in status register one.
  localparam int SR_BUSY  = 0;
  localparam int SR_WEL   = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 4;
  localparam int SR_EERR  = 5;
  localparam int SR_PERR  = 6;
  localparam int SR_LOCK  = 7;

  localparam logic [2:0] BP_VOL_RESET = 3'h7;
  localparam logic [7:0] SR2_VALUE    = 8'h00;

  // Bytes a command needs before it may execute.
  localparam logic [2:0] WRR_BYTES  = 3'h2;
  localparam logic [2:0] ADDR_BYTES = 3'h4;

  // Register write time.
  localparam int CLK_PERIOD_NS = 10;
  localparam int REG_WRITE_NS  = 1000;
  localparam int REG_WRITE_CYC =
    (REG_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CORE_NONE  = 2'b00,
    CORE_PROG  = 2'b01,
    CORE_SECT  = 2'b10,
    CORE_BULK  = 2'b11
  } fsrl_op_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_REGWR = 2'b01,
    ST_CORE  = 2'b10,
    ST_ERROR = 2'b11
  } fsrl_state_e;

endpackage

/* src/fsrl_serial.sv */
// Serial byte shifter for the flash status register logic.
// Samples the serial pins with the system clock; mode 0 framing.
`timescale 1ns/1ns
`default_nettype none
module fsrl_serial (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  input  wire logic [7:0] tx_byte_in,
  output logic      [7:0] byte_out,
  output logic            byte_valid_out,
  output logic            frame_start_out,
  output logic            frame_end_out,
  output logic            active_out,
  output logic            so_out
);
  logic [2:0] sck_p, cs_p, si_p;
  logic [2:0] next_sck_p, next_cs_p, next_si_p;
  logic [2:0] cnt, next_cnt;
  logic [7:0] rx, next_rx, tx, next_tx;
  logic [7:0] next_byte;
  logic       started, next_started;
  logic       next_valid, next_fs, next_fe, next_so;
  logic       rise, fall;

  always_comb begin
    next_sck_p = {sck_p[1:0], sck_in};
    next_cs_p  = {cs_p[1:0], cs_n_in};
    next_si_p  = {si_p[1:0], si_in};
    rise       = sck_p[1] & ~sck_p[2];
    fall       = ~sck_p[1] & sck_p[2];
    next_cnt   = cnt;
    next_rx    = rx;
    next_tx    = tx;
    next_byte  = byte_out;
    next_started = started;
    next_so    = so_out;
    next_valid = 1'b0;
    next_fs    = ~cs_p[1] & cs_p[2];
    next_fe    = cs_p[1] & ~cs_p[2];
    if (next_fs) begin
      next_cnt     = 3'h0;
      next_started = 1'b0;
    end else if (!cs_p[1] && rise) begin
      next_rx      = {rx[6:0], si_p[1]};
      next_cnt     = cnt + 3'h1;
      next_started = 1'b1;
      if (cnt == 3'h7) begin
        next_valid = 1'b1;
        next_byte  = {rx[6:0], si_p[1]};
      end
    end else if (!cs_p[1] && fall) begin
      // A new reply byte is taken at each byte boundary after the first byte of the frame.
      if (cnt == 3'h0 && started) begin
        next_so = tx_byte_in[7];
        next_tx = {tx_byte_in[6:0], 1'b0};
      end else begin
        next_so = tx[7];
        next_tx = {tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sck_p <= 3'h0;
      cs_p  <= 3'h7;
      si_p  <= 3'h0;
      cnt   <= 3'h0;
      rx    <= 8'h00;
      tx    <= 8'h00;
      byte_out <= 8'h00;
      started  <= 1'b0;
      so_out   <= 1'b0;
      byte_valid_out  <= 1'b0;
      frame_start_out <= 1'b0;
      frame_end_out   <= 1'b0;
    end else begin
      sck_p <= next_sck_p;
      cs_p  <= next_cs_p;
      si_p  <= next_si_p;
      cnt   <= next_cnt;
      rx    <= next_rx;
      tx    <= next_tx;
      byte_out <= next_byte;
      started  <= next_started;
      so_out   <= next_so;
      byte_valid_out  <= next_valid;
      frame_start_out <= next_fs;
      frame_end_out   <= next_fe;
    end
  end

  assign active_out = ~cs_p[2];
endmodule
`default_nettype wire

/* src/fsrl_status.sv */
// Status register one of a serial flash with command gating.
// Array operations run in an outside core; protection range and
// non-volatile storage are supplied from outside on this clock.
`timescale 1ns/1ns
`default_nettype none
module fsrl_status
  import fsrl_pkg::*;
#(
  parameter int AW      = 24,
  parameter int REG_CYC = REG_WRITE_CYC
) (
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  input  wire logic          sck_in,
  input  wire logic          cs_n_in,
  input  wire logic          si_in,
  input  wire logic          wp_n_in,
  input  wire logic          hw_reset_n_in,
  input  wire logic          cfg_bp_volatile_in,
  input  wire logic          nv_lock_in,
  input  wire logic [2:0]    nv_bp_in,
  input  wire logic [AW-1:0] prot_lo_in,
  input  wire logic [AW-1:0] prot_hi_in,
  input  wire logic          core_done_in,
  input  wire logic          core_fail_in,
  input  wire logic          core_prot_hit_in,
  output logic               so_out,
  output logic               so_oe_out,
  output logic               nv_write_out,
  output logic               nv_lock_out,
  output logic [2:0]         nv_bp_out,
  output logic [2:0]         block_protect_out,
  output logic               core_start_out,
  output logic [1:0]         core_op_out,
  output logic [AW-1:0]      core_addr_out,
  output logic               core_abort_out,
  output logic               prog_suspend_out,
  output logic               erase_suspend_out,
  output logic [7:0]         status_out
);
  localparam int CW = $clog2(REG_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(REG_CYC - 1);

  logic [7:0]    rx_byte, tx_byte;
  logic          byte_valid, frame_start, frame_end, active;
  logic [1:0]    wp_s, hr_s, next_wp_s, next_hr_s;
  fsrl_state_e   state, next_state;
  fsrl_op_e      op, next_op;
  logic [CW-1:0] cnt, next_cnt;
  logic [7:0]    opcode, next_opcode, wrdata, next_wrdata;
  logic [2:0]    nbytes, next_nbytes;
  logic [AW-1:0] addr, next_addr;
  logic          write_enable_latch, perr, eerr, next_wel, next_perr, next_eerr;
  logic [2:0]    bp_vol, next_bp_vol, next_nv_bp;
  logic          next_nv_write, next_nv_lock, next_start, next_abort;
  logic          next_program_suspend_cmd, next_erase_suspend_cmd, hr_d, next_hr_d;
  logic          busy, hw_prot, in_prot, sw_reset, do_reset;
  logic [2:0]    bp;

  fsrl_serial u_serial (
    .clock_in        (clock_in),
    .reset_in        (reset_in),
    .sck_in          (sck_in),
    .cs_n_in         (cs_n_in),
    .si_in           (si_in),
    .tx_byte_in      (tx_byte),
    .byte_out        (rx_byte),
    .byte_valid_out  (byte_valid),
    .frame_start_out (frame_start),
    .frame_end_out   (frame_end),
    .active_out      (active),
    .so_out          (so_out)
  );

  assign busy    = (state != ST_IDLE);
  assign bp      = cfg_bp_volatile_in ? bp_vol : nv_bp_in;
  assign hw_prot = nv_lock_in & ~wp_s[1];
  assign in_prot = (bp != 3'h0) && (addr >= prot_lo_in)
                   && (addr <= prot_hi_in);
  assign status_out = {nv_lock_in, perr, eerr, bp, write_enable_latch, busy};
  assign block_protect_out = bp;
  assign tx_byte = (opcode == OP_READ_STATUS_ONE_CMD) ? status_out : SR2_VALUE;
  assign so_oe_out = active && (nbytes != 3'h0) &&
                     (opcode == OP_READ_STATUS_ONE_CMD || opcode == OP_READ_STATUS_TWO_CMD);
  assign sw_reset = frame_end && (opcode == OP_SRST) && (nbytes != 3'h0);
  assign do_reset = sw_reset | (hr_s[1] & ~hr_d);

  always_comb begin
    next_wp_s   = {wp_s[0], wp_n_in};
    next_hr_s   = {hr_s[0], ~hw_reset_n_in};
    next_hr_d   = hr_s[1];
    next_state  = state;
    next_op     = op;
    next_cnt    = cnt;
    next_opcode = opcode;
    next_wrdata = wrdata;
    next_nbytes = nbytes;
    next_addr   = addr;
    next_wel    = write_enable_latch;
    next_perr   = perr;
    next_eerr   = eerr;
    next_bp_vol = bp_vol;
    next_nv_bp  = nv_bp_out;
    next_nv_lock  = nv_lock_out;
    next_nv_write = 1'b0;
    next_start  = 1'b0;
    next_abort  = 1'b0;
    next_program_suspend_cmd   = 1'b0;
    next_erase_suspend_cmd   = 1'b0;
    if (frame_start) begin
      next_nbytes = 3'h0;
    end else if (byte_valid) begin
      if (nbytes == 3'h0) begin
        next_opcode = rx_byte;
      end else if (nbytes < ADDR_BYTES) begin
        next_addr = {addr[AW-9:0], rx_byte};
      end
      if (nbytes == 3'h1) begin
        next_wrdata = rx_byte;
      end
      if (nbytes != 3'h7) begin
        next_nbytes = nbytes + 3'h1;
      end
    end
    if (frame_end && nbytes != 3'h0) begin
      // Commands not listed here take no action here; status reads and reset are handled apart.
      case (opcode)
        OP_SET_WRITE_ENABLE_CMD: begin
          if (!busy) next_wel = 1'b1;
        end
        OP_CLEAR_WRITE_ENABLE_CMD: begin
          if (!busy) next_wel = 1'b0;
        end
        OP_CLEAR_STATUS_CMD: begin
          next_perr = 1'b0;
          next_eerr = 1'b0;
          if (state == ST_ERROR) next_state = ST_IDLE;
        end
        OP_WRR: begin
          if (!busy && write_enable_latch && !hw_prot &&
              nbytes >= WRR_BYTES) begin
            next_state = ST_REGWR;
            next_cnt   = '0;
          end
        end
        OP_PROG, OP_SECT: begin
          if (!busy && write_enable_latch && nbytes >= ADDR_BYTES) begin
            if (in_prot) begin
              next_perr  = (opcode == OP_PROG) | perr;
              next_eerr  = (opcode == OP_SECT) | eerr;
              next_state = ST_ERROR;
            end else begin
              next_state = ST_CORE;
              next_start = 1'b1;
              next_op = (opcode == OP_PROG) ? CORE_PROG : CORE_SECT;
            end
          end
        end
        OP_BULK: begin
          if (!busy && write_enable_latch && bp == 3'h0) begin
            next_state = ST_CORE;
            next_start = 1'b1;
            next_op    = CORE_BULK;
          end
        end
        OP_PROGRAM_SUSPEND_CMD: begin
          next_program_suspend_cmd = (state == ST_CORE) && (op == CORE_PROG);
        end
        OP_ERASE_SUSPEND_CMD: begin
          next_erase_suspend_cmd = (state == ST_CORE) &&
                      (op == CORE_SECT || op == CORE_BULK);
        end
        default: begin
        end
      endcase
    end
    case (state)
      ST_REGWR: begin
        next_cnt = cnt + CW'(1);
        if (cnt == CNT_LAST) begin
          next_nv_write = 1'b1;
          next_nv_lock  = wrdata[SR_LOCK];
          next_nv_bp    = cfg_bp_volatile_in ? nv_bp_in
                          : wrdata[SR_BP_HI:SR_BP_LO];
          if (cfg_bp_volatile_in) begin
            next_bp_vol = wrdata[SR_BP_HI:SR_BP_LO];
          end
          next_wel   = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_CORE: begin
        if (core_done_in) begin
          if (core_fail_in && !(op == CORE_BULK && core_prot_hit_in)) begin
            next_perr  = (op == CORE_PROG) | next_perr;
            next_eerr  = (op != CORE_PROG) | next_eerr;
            next_state = ST_ERROR;
          end else begin
            next_wel   = 1'b0;
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
    if (do_reset) begin
      next_wel    = 1'b0;
      next_perr   = 1'b0;
      next_eerr   = 1'b0;
      next_state  = ST_IDLE;
      next_bp_vol = BP_VOL_RESET;
      next_abort  = busy;
      next_nv_write = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wp_s   <= 2'h3;
      hr_s   <= 2'h0;
      hr_d   <= 1'b0;
      state  <= ST_IDLE;
      op     <= CORE_NONE;
      cnt    <= '0;
      opcode <= 8'h00;
      wrdata <= 8'h00;
      nbytes <= 3'h0;
      addr   <= '0;
      write_enable_latch    <= 1'b0;
      perr   <= 1'b0;
      eerr   <= 1'b0;
      bp_vol <= BP_VOL_RESET;
      nv_bp_out    <= 3'h0;
      nv_lock_out  <= 1'b0;
      nv_write_out <= 1'b0;
      core_start_out    <= 1'b0;
      core_abort_out    <= 1'b0;
      prog_suspend_out  <= 1'b0;
      erase_suspend_out <= 1'b0;
    end else begin
      wp_s   <= next_wp_s;
      hr_s   <= next_hr_s;
      hr_d   <= next_hr_d;
      state  <= next_state;
      op     <= next_op;
      cnt    <= next_cnt;
      opcode <= next_opcode;
      wrdata <= next_wrdata;
      nbytes <= next_nbytes;
      addr   <= next_addr;
      write_enable_latch    <= next_wel;
      perr   <= next_perr;
      eerr   <= next_eerr;
      bp_vol <= next_bp_vol;
      nv_bp_out    <= next_nv_bp;
      nv_lock_out  <= next_nv_lock;
      nv_write_out <= next_nv_write;
      core_start_out    <= next_start;
      core_abort_out    <= next_abort;
      prog_suspend_out  <= next_program_suspend_cmd;
      erase_suspend_out <= next_erase_suspend_cmd;
    end
  end

  assign core_op_out   = op;
  assign core_addr_out = addr;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_cmd_end(logic [7:0] code);
    frame_end && nbytes != 3'h0 && opcode == code && !do_reset;
  endsequence
  sequence s_op_ok;
    state == ST_CORE && core_done_in && !core_fail_in && !do_reset;
  endsequence

  a_wrr_locked: assert property (
    s_cmd_end(OP_WRR) and (hw_prot && !busy) |=> state == ST_IDLE)
    else $error("register write taken while locked");
  a_wrr_accept: assert property (
    s_cmd_end(OP_WRR) and (!hw_prot && write_enable_latch && !busy && nbytes >= WRR_BYTES)
    |=> state == ST_REGWR)
    else $error("register write not started");
  a_prot_perr: assert property (
    s_cmd_end(OP_PROG) and (!busy && write_enable_latch && in_prot && nbytes >= ADDR_BYTES)
    |=> perr && state == ST_ERROR && !core_start_out)
    else $error("protected program did not flag");
  a_err_sticky: assert property (
    perr && !(frame_end && opcode == OP_CLEAR_STATUS_CMD) && !do_reset |=> perr)
    else $error("program error lost without clear");
  a_bulk_block: assert property (
    s_cmd_end(OP_BULK) and (bp != 3'h0) |=> !core_start_out)
    else $error("whole erase ran with protection");
  a_wel_set: assert property (
    s_cmd_end(OP_SET_WRITE_ENABLE_CMD) and !busy |=> write_enable_latch)
    else $error("enable latch not set");
  a_wel_gate: assert property (
    frame_end && !write_enable_latch |=> !core_start_out && state != ST_REGWR)
    else $error("operation started without latch");
  a_done_clear: assert property (
    s_op_ok |=> !write_enable_latch && state == ST_IDLE)
    else $error("success did not clear latch");
  a_err_busy: assert property (
    (perr || eerr) |-> busy)
    else $error("error without busy");
  a_reset_vals: assert property (disable iff (1'b0)
    reset_in |=> !write_enable_latch && !perr && !eerr && !busy)
    else $error("reset defaults wrong");
  a_regwr_time: assert property (
    state == ST_IDLE ##1 state == ST_REGWR && !do_reset |->
    busy [*4])
    else $error("busy dropped during register write");
endmodule
`default_nettype wire

/* tb/flash_status_register_logic_bench.sv */
// Self-checking bench for the flash status register logic.
// Plays the array core and the non-volatile store; host model on the pins.
`timescale 1ns/1ns
`default_nettype none
module flash_status_register_logic_bench
  import fsrl_pkg::*;
;
  logic        clock_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        sck_in, cs_n_in, si_in, so_out, so_oe_out;
  logic        wp_n_in = 1'b1;
  logic        hw_reset_n_in = 1'b1;
  logic        cfg_bp_volatile_in = 1'b1;
  logic        nv_lock_in = 1'b0;
  logic [2:0]  nv_bp_in = 3'h0;
  logic [23:0] prot_lo_in = 24'h100000;
  logic [23:0] prot_hi_in = 24'h1fffff;
  logic        core_done_in = 1'b0;
  logic        core_fail_in, core_prot_hit_in, nv_write_out, nv_lock_out;
  logic        core_start_out, core_abort_out, prog_suspend_out;
  logic        erase_suspend_out, fail_next, hit_next;
  logic [2:0]  nv_bp_out, block_protect_out, e_bp;
  logic [1:0]  core_op_out;
  logic [23:0] core_addr_out;
  logic [7:0]  status_out, r;
  logic        e_lock, e_perr, e_eerr, e_wel, e_busy;
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_start = 0;
  int          n_psp = 0;
  int          n_esp = 0;
  int          cnt = 0;

  always #5 clock_in = ~clock_in;

  fsrl_status #(.REG_CYC(4)) fsrl_status_i (
    .clock_in, .reset_in, .sck_in, .cs_n_in, .si_in, .wp_n_in,
    .hw_reset_n_in, .cfg_bp_volatile_in, .nv_lock_in, .nv_bp_in,
    .prot_lo_in, .prot_hi_in, .core_done_in, .core_fail_in,
    .core_prot_hit_in, .so_out, .so_oe_out, .nv_write_out, .nv_lock_out,
    .nv_bp_out, .block_protect_out, .core_start_out, .core_op_out,
    .core_addr_out, .core_abort_out, .prog_suspend_out,
    .erase_suspend_out, .status_out);

  fsrl_host fsrl_host_i (.clock_in, .so_in(so_out), .sck_out(sck_in),
    .cs_n_out(cs_n_in), .si_out(si_in));

  assign core_fail_in = core_done_in & fail_next;
  assign core_prot_hit_in = core_done_in & hit_next;

  // Array core with a long run time, and the non-volatile store.
  always @(negedge clock_in) begin
    core_done_in = 1'b0;
    if (nv_write_out) begin
      nv_lock_in = nv_lock_out;
      nv_bp_in = nv_bp_out;
    end
    n_start += int'(core_start_out);
    n_psp += int'(prog_suspend_out);
    n_esp += int'(erase_suspend_out);
    if (core_abort_out) cnt = 0;
    else if (core_start_out) cnt = 1500;
    else if (cnt > 0) begin
      cnt--;
      core_done_in = (cnt == 0);
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] exp_sr();
    return {e_lock, e_perr, e_eerr, e_bp, e_wel, e_busy};
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic send(input int n, input logic [31:0] tx);
    logic [31:0] rx;
    fsrl_host_i.xfer(n, tx, rx);
  endtask

  task automatic chk_sr(input logic [7:0] mask);
    logic [31:0] rx;
    fsrl_host_i.xfer(2, {OP_READ_STATUS_ONE_CMD, 24'h0}, rx);
    chk("status", exp_sr() & mask, rx[7:0] & mask);
  endtask

  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 3000 && status_out[b] !== v; i++)
      @(negedge clock_in);
    if (i == 3000) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic set_write_enable_cmd();
    send(1, {OP_SET_WRITE_ENABLE_CMD, 24'h0});
    e_wel = 1'b1;
  endtask

  task automatic write_registers_cmd(input logic [7:0] d);
    set_write_enable_cmd();
    send(2, {OP_WRR, d, 16'h0});
    wait_bit(SR_BUSY, 1'b0);
    e_lock = d[7];
    e_bp = d[4:2];
    e_wel = 1'b0;
  endtask

  initial begin
    {e_lock, e_perr, e_eerr, e_wel, e_busy} = 5'h0;
    e_bp = BP_VOL_RESET;
    {fail_next, hit_next} = 2'h0;
    r = 8'h31;
    repeat (20) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (8) @(negedge clock_in);
    chk_sr(8'hff);
    send(2, {OP_WRR, 8'h9c, 16'h0});
    chk_sr(8'hff);
    set_write_enable_cmd();
    chk_sr(8'hff);
    send(1, {OP_CLEAR_WRITE_ENABLE_CMD, 24'h0});
    e_wel = 1'b0;
    chk_sr(8'hff);
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      write_registers_cmd(r);
      chk_sr(8'hff);
    end
    // Locked with the protect pin low: register write and bulk refused.
    write_registers_cmd(8'h84);
    wp_n_in = 1'b0;
    set_write_enable_cmd();
    send(2, {OP_WRR, 8'h00, 16'h0});
    send(1, {OP_BULK, 24'h0});
    chk_sr(8'hff);
    chk("starts", 8'h0, 8'(n_start));
    wp_n_in = 1'b1;
    write_registers_cmd(8'h00);
    chk_sr(8'hff);
    // Bulk erase that fails only on a protected sector ends cleanly.
    {fail_next, hit_next} = 2'h3;
    set_write_enable_cmd();
    send(1, {OP_BULK, 24'h0});
    e_busy = 1'b1;
    send(1, {OP_PROGRAM_SUSPEND_CMD, 24'h0});
    send(1, {OP_ERASE_SUSPEND_CMD, 24'h0});
    chk_sr(8'hff);
    wait_bit(SR_BUSY, 1'b0);
    {e_busy, e_wel, hit_next, fail_next} = 4'h0;
    chk_sr(8'hff);
    set_write_enable_cmd();
    r = lfsr(r);
    send(4, {OP_PROG, 8'h00, r, 8'h00});
    e_busy = 1'b1;
    send(1, {OP_CLEAR_WRITE_ENABLE_CMD, 24'h0});
    send(1, {OP_ERASE_SUSPEND_CMD, 24'h0});
    send(1, {OP_PROGRAM_SUSPEND_CMD, 24'h0});
    chk_sr(8'hff);
    chk("core op", 8'(CORE_PROG), 8'(core_op_out));
    wait_bit(SR_BUSY, 1'b0);
    {e_busy, e_wel} = 2'h0;
    chk_sr(8'hff);
    chk("suspends", 8'h11, {n_psp[3:0], n_esp[3:0]});
    fail_next = 1'b1;
    set_write_enable_cmd();
    send(4, {OP_PROG, 24'h0000a0});
    wait_bit(SR_PERR, 1'b1);
    {e_perr, e_busy} = 2'h3;
    chk_sr(8'hfd);
    send(1, {OP_CLEAR_STATUS_CMD, 24'h0});
    send(1, {OP_CLEAR_WRITE_ENABLE_CMD, 24'h0});
    {e_perr, e_busy, e_wel, fail_next} = 4'h0;
    chk_sr(8'hff);
    // Targets inside the decoded range, with random protect bits.
    r = lfsr(r);
    write_registers_cmd({3'h4, r[4:2] | 3'h1, 2'h0});
    for (int k = 0; k < 2; k++) begin
      set_write_enable_cmd();
      send(4, {k[0] ? OP_SECT : OP_PROG, 8'h10, r, 8'h00});
      wait_bit(k[0] ? SR_EERR : SR_PERR, 1'b1);
      {e_eerr, e_perr, e_busy} = {k[0], ~k[0], 1'b1};
      chk_sr(8'hfd);
      if (k == 0) begin
        send(1, {OP_CLEAR_STATUS_CMD, 24'h0});
        send(1, {OP_CLEAR_WRITE_ENABLE_CMD, 24'h0});
        {e_perr, e_busy, e_wel} = 3'h0;
      end
    end
    chk("starts", 8'h3, 8'(n_start));
    send(1, {OP_SRST, 24'h0});
    {e_eerr, e_busy, e_wel} = 3'h0;
    e_bp = BP_VOL_RESET;
    chk_sr(8'hff);
    set_write_enable_cmd();
    hw_reset_n_in = 1'b0;
    repeat (8) @(negedge clock_in);
    hw_reset_n_in = 1'b1;
    repeat (8) @(negedge clock_in);
    e_wel = 1'b0;
    chk_sr(8'hff);
    cfg_bp_volatile_in = 1'b0;
    write_registers_cmd(8'h88);
    chk_sr(8'hff);
    reset_in = 1'b1;
    repeat (20) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (8) @(negedge clock_in);
    chk_sr(8'hff);
    end_of_test();
  end
endmodule
`default_nettype wire

/* tb/fsrl_host.sv */
// Host controller model that issues serial flash command frames.
// Assumes mode 0 framing and a link half period of eight system clocks.
`timescale 1ns/1ns
`default_nettype none
module fsrl_host (
  input  wire logic clock_in,
  input  wire logic so_in,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // Sends n bytes from the top of tx, MSB first, and returns what so held
  // at each rising link edge. The link clock stays low between frames.
  task automatic xfer(input int n, input logic [31:0] tx,
                      output logic [31:0] rx);
    rx = 32'h0;
    cs_n_out = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si_out = tx[31 - i];
      repeat (8) @(negedge clock_in);
      sck_out = 1'b1;
      rx = {rx[30:0], so_in};
      repeat (8) @(negedge clock_in);
      sck_out = 1'b0;
    end
    repeat (8) @(negedge clock_in);
    cs_n_out = 1'b1;
    // A released data line does not keep its last level.
    si_out = ~si_out;
    repeat (8) @(negedge clock_in);
  endtask
endmodule
`default_nettype wire
